// *** aux_pin1_output_mux.sv ***
// output selector and control register for auxiliary pin one
//
// Notes on behaviour
// - source field: 0-3 receive ports, 4 device status, 5 reserved, 6-7 transmit ports
// - receive source: code 000 gives remote pin 0, code 011 remote pin 3
// - receive source: code 100 gives port lock, 101 gives port pass
// - receive source: code 110 gives frame valid, 111 gives line valid
// - device status: code 000 gives the local value bit of this register
// - device status: code 001 gives OR of lock over enabled receive ports
// - device status: code 010 gives AND of lock over enabled receive ports
// - device status: code 011 gives AND of pass over enabled receive ports
// - transmit source: 000 AND, 001 OR of pass over its selected receive ports
// - transmit source: 010 sending frame, 011 sending line
// - transmit source: 100 synchronized, 101 port interrupt, 111 reserved
// - software-written value bit is held and driven when locally selected
// - pin driver enabled only while enable bit 0 is one
// - control register resets to zero: disabled, receive port 0, code 000
`timescale 1ns/1ps
`include "aux_pin_cfg.svh"

module aux_pin1_output_mux
    import aux_pin_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [15:0] rxRemotePins,
    input wire logic [3:0] rxLock,
    input wire logic [3:0] rxPass,
    input wire logic [3:0] rxFrameValid,
    input wire logic [3:0] rxLineValid,
    input wire logic [3:0] rxPortEnable,
    input wire logic frameSyncPulse,
    input wire logic [7:0] txRxSelect,
    input wire logic [1:0] txFrameActive,
    input wire logic [1:0] txLineActive,
    input wire logic [1:0] txSynced,
    input wire logic [1:0] txInterrupt,
    output logic auxPinOneOut,
    output logic auxPinOneOe
);

    logic [7:0] pinCtl_r;
    logic [7:0] pinCtl_nxt;
    logic wrCtl_r;
    logic rdCtl_r;
    logic rdStat_r;
    logic pinOut_r;
    logic pinOe_r;
    logic pinValue;
    logic [3:0] rxSig;

    // bus address phase decode; single word transfers only, hsize unused
    wire addrPhase = hsel & hready & htrans[1];
    wire hitCtl = (haddr == `AUX_CTL_ADDR);
    wire hitStat = (haddr == `AUX_STAT_ADDR);
    wire wrCtlReq = addrPhase & hwrite & hitCtl;
    wire rdCtlReq = addrPhase & ~hwrite & hitCtl;
    wire rdStatReq = addrPhase & ~hwrite & hitStat;
    wire unusedSize = ^hsize;

    // zero wait states and always OKAY; unmapped reads return zero
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdCtl_r ? {24'h000000, pinCtl_r} :
                    rdStat_r ? {30'h00000000, pinOe_r, pinOut_r} : 32'h0000_0000;

    // data phase write lands at the end of the data phase
    // hready is not re-checked in the data phase: this slave is the only one
    // on the bus and never stretches a transfer
    assign pinCtl_nxt = wrCtl_r ? hwdata[7:0] : pinCtl_r;

    // control register fields
    wire [2:0] pinSignalSelect = pinCtl_r[`AUX_SEL_HI:`AUX_SEL_LO];
    wire [2:0] pinSourceSelect = pinCtl_r[`AUX_SRC_HI:`AUX_SRC_LO];
    wire pinLocalValue = pinCtl_r[`AUX_VAL_BIT];
    wire pinOutputEnable = pinCtl_r[`AUX_EN_BIT];

    // one selector per receive port, then pick the addressed port
    // four small copies cost a few gates but keep each port's encoding in one place;
    // the port pick comes after, so the select decode is shared
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gRx
            rx_sig_select uSel (
                .pinSignalSelect(pinSignalSelect),
                .remotePins(rxRemotePins[4*g +: 4]),
                .lock(rxLock[g]),
                .pass(rxPass[g]),
                .frameValid(rxFrameValid[g]),
                .lineValid(rxLineValid[g]),
                .sig(rxSig[g])
            );
        end
    endgenerate
    wire rxChosen = rxSig[pinSourceSelect[1:0]];

    // device status aggregates; with no port enabled the AND terms read low
    // (an empty AND would otherwise read high and fake a full lock)
    wire anyEnabled = |rxPortEnable;
    wire lockOr = |(rxLock & rxPortEnable);
    wire lockAnd = anyEnabled & (&(rxLock | ~rxPortEnable));
    wire passAnd = anyEnabled & (&(rxPass | ~rxPortEnable));
    // reserved codes read low so a stray setting never toggles the pin
    wire [7:0] devVec = {3'b000, frameSyncPulse, passAnd, lockAnd, lockOr, pinLocalValue};
    wire devChosen = devVec[pinSignalSelect];

    // transmit port status over the receive ports that feed it
    // an empty mask gives a low pass AND, same reasoning as above
    wire txIdx = pinSourceSelect[0];
    wire [3:0] txMask = txIdx ? txRxSelect[7:4] : txRxSelect[3:0];
    wire txPassAnd = (|txMask) & (&(rxPass | ~txMask));
    wire txPassOr = |(rxPass & txMask);
    wire [7:0] txVec = {2'b00, txInterrupt[txIdx], txSynced[txIdx], txLineActive[txIdx],
                        txFrameActive[txIdx], txPassOr, txPassAnd};
    wire txChosen = txVec[pinSignalSelect];

    // source group selection
    always_comb begin
        case (pinSourceSelect)
            SRC_RX0, SRC_RX1, SRC_RX2, SRC_RX3: pinValue = rxChosen;
            SRC_DEV: pinValue = devChosen;
            SRC_TX0, SRC_TX1: pinValue = txChosen;
            default: pinValue = 1'b0;
        endcase
    end

    // bus phase tracking
    // one flag per access kind, held for the single data phase cycle;
    // back to back transfers simply reload them every edge
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wrCtl_r <= 1'b0;
            rdCtl_r <= 1'b0;
            rdStat_r <= 1'b0;
        end else begin
            wrCtl_r <= wrCtlReq;
            rdCtl_r <= rdCtlReq;
            rdStat_r <= rdStatReq | unusedSize & 1'b0;
        end
    end

    // control register
    // only the low byte is kept; upper write data is dropped on purpose
    // and reads back as zero
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pinCtl_r <= `AUX_CTL_RESET;
        end else begin
            pinCtl_r <= pinCtl_nxt;
        end
    end

    // registered pin drive so the pin never glitches on a mux change
    // costs one cycle of latency from any setting or status to the pin;
    // the value keeps toggling while the driver is off
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pinOut_r <= 1'b0;
            pinOe_r <= 1'b0;
        end else begin
            pinOut_r <= pinValue;
            pinOe_r <= pinOutputEnable;
        end
    end

    assign auxPinOneOut = pinOut_r;
    assign auxPinOneOe = pinOe_r;

    // checks on the selector, one cycle from settings to pin
    // each selector check compares the pin one edge after the selection it names;
    // expected values are rebuilt from the raw status inputs where they can be,
    // so a wrong aggregate in the selector shows up
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    property pResetClear;
        @(posedge ref_clk) disable iff (1'b0) srst |=> (pinCtl_r == 8'h00) ##1 !auxPinOneOe;
    endproperty
    reset_clears_a: assert property (pResetClear)
        else $error("control not cleared after reset");

    oe_follows_en_a: assert property ($past(!srst) |-> auxPinOneOe == $past(pinOutputEnable))
        else $error("pin enable does not follow control bit");

    ctl_write_a: assert property (wrCtlReq ##1 hready |=> pinCtl_r == $past(hwdata[7:0]))
        else $error("control write not stored");

    local_value_a: assert property ((pinSourceSelect == SRC_DEV && pinSignalSelect == 3'h0)
        |=> auxPinOneOut == $past(pinLocalValue))
        else $error("local value not on pin");

    rx_remote_a: assert property ((!pinSourceSelect[2] && !pinSignalSelect[2])
        |=> auxPinOneOut == $past(rxRemotePins[{pinSourceSelect[1:0], pinSignalSelect[1:0]}]))
        else $error("wrong remote pin forwarded");

    rx_status_a: assert property ((!pinSourceSelect[2] && pinSignalSelect == 3'h5)
        |=> auxPinOneOut == $past(rxPass[pinSourceSelect[1:0]]))
        else $error("wrong receive pass status");

    rx_line_a: assert property ((!pinSourceSelect[2] && pinSignalSelect == 3'h7)
        |=> auxPinOneOut == $past(rxLineValid[pinSourceSelect[1:0]]))
        else $error("wrong line valid");

    lock_or_a: assert property ((pinSourceSelect == SRC_DEV && pinSignalSelect == 3'h1)
        |=> auxPinOneOut == $past(|(rxLock & rxPortEnable)))
        else $error("lock OR wrong");

    dev_reserved_a: assert property ((pinSourceSelect == SRC_DEV && pinSignalSelect > 3'h4)
        |=> !auxPinOneOut)
        else $error("reserved status code drove pin");

    src_reserved_a: assert property (pinSourceSelect == SRC_RSVD |=> !auxPinOneOut)
        else $error("reserved source drove pin");

    tx_intr_a: assert property ((pinSourceSelect[2:1] == 2'b11 && pinSignalSelect == 3'h5)
        |=> auxPinOneOut == $past(txInterrupt[pinSourceSelect[0]]))
        else $error("transmit interrupt not on pin");

    // receive port sources
    rx_lock_a: assert property ((!pinSourceSelect[2] && pinSignalSelect == 3'h4)
        |=> auxPinOneOut == $past(rxLock[pinSourceSelect[1:0]]))
        else $error("wrong receive lock status");

    rx_frame_a: assert property ((!pinSourceSelect[2] && pinSignalSelect == 3'h6)
        |=> auxPinOneOut == $past(rxFrameValid[pinSourceSelect[1:0]]))
        else $error("wrong frame valid");

    rx_mid_a: assert property ((!pinSourceSelect[2] && (pinSignalSelect == 3'h1 || pinSignalSelect == 3'h2))
        |=> auxPinOneOut == $past(rxRemotePins[{pinSourceSelect[1:0], pinSignalSelect[1:0]}]))
        else $error("wrong middle remote pin");

    // device status source
    lock_and_a: assert property ((pinSourceSelect == SRC_DEV && pinSignalSelect == 3'h2)
        |=> auxPinOneOut == ((|$past(rxPortEnable)) && (&($past(rxLock) | ~$past(rxPortEnable)))))
        else $error("lock AND wrong");

    pass_and_a: assert property ((pinSourceSelect == SRC_DEV && pinSignalSelect == 3'h3)
        |=> auxPinOneOut == ((|$past(rxPortEnable)) && (&($past(rxPass) | ~$past(rxPortEnable)))))
        else $error("pass AND wrong");

    fsync_a: assert property ((pinSourceSelect == SRC_DEV && pinSignalSelect == 3'h4)
        |=> auxPinOneOut == $past(frameSyncPulse))
        else $error("frame sync not on pin");

    // transmit port sources
    tx_pass_and_a: assert property ((pinSourceSelect[2:1] == 2'b11 && pinSignalSelect == 3'h0)
        |=> auxPinOneOut == ((|$past(txRxSelect[4*pinSourceSelect[0] +: 4]))
        && (&($past(rxPass) | ~$past(txRxSelect[4*pinSourceSelect[0] +: 4])))))
        else $error("transmit pass AND wrong");

    tx_pass_or_a: assert property ((pinSourceSelect[2:1] == 2'b11 && pinSignalSelect == 3'h1)
        |=> auxPinOneOut ==
        (|($past(rxPass) & $past(txRxSelect[4*pinSourceSelect[0] +: 4]))))
        else $error("transmit pass OR wrong");

    tx_frame_a: assert property ((pinSourceSelect[2:1] == 2'b11 && pinSignalSelect == 3'h2)
        |=> auxPinOneOut == $past(txFrameActive[pinSourceSelect[0]]))
        else $error("transmit frame flag not on pin");

    tx_line_a: assert property ((pinSourceSelect[2:1] == 2'b11 && pinSignalSelect == 3'h3)
        |=> auxPinOneOut == $past(txLineActive[pinSourceSelect[0]]))
        else $error("transmit line flag not on pin");

    tx_synced_a: assert property ((pinSourceSelect[2:1] == 2'b11 && pinSignalSelect == 3'h4)
        |=> auxPinOneOut == $past(txSynced[pinSourceSelect[0]]))
        else $error("transmit sync flag not on pin");

    tx_reserved_a: assert property ((pinSourceSelect[2:1] == 2'b11 && pinSignalSelect > 3'h5)
        |=> !auxPinOneOut)
        else $error("reserved transmit code drove pin");

    // register bus and reset
    ctl_hold_a: assert property (!wrCtl_r |=> $stable(pinCtl_r))
        else $error("control changed without a write");

    read_data_a: assert property (rdCtl_r |-> hrdata == {24'h000000, pinCtl_r})
        else $error("control read data wrong");

    stat_read_a: assert property (rdStat_r |-> hrdata == {30'h00000000, auxPinOneOe, auxPinOneOut})
        else $error("status read data wrong");

    reset_pin_a: assert property (@(posedge ref_clk) disable iff (1'b0) srst |=> !auxPinOneOut)
        else $error("pin value not cleared by reset");

    // main scenarios
    cover_local_c: cover property (pinSourceSelect == SRC_DEV && pinOutputEnable ##1 auxPinOneOe);
    cover_rx_lock_c: cover property (!pinSourceSelect[2] && pinSignalSelect == 3'h4 && rxLock != 4'h0);
    cover_tx_pass_c: cover property (pinSourceSelect == SRC_TX1 && txPassAnd);
    cover_write_c: cover property (wrCtlReq ##1 rdCtlReq);
    cover_tx_frame_c: cover property (pinSourceSelect == SRC_TX0 && pinSignalSelect == 3'h2 && txFrameActive[0]);

endmodule // aux_pin1_output_mux

// *** aux_pin_cfg.svh ***
// offsets, field positions and reset values for the auxiliary pin control
`ifndef AUX_PIN_CFG_SVH
`define AUX_PIN_CFG_SVH

// register index as printed; the bus byte address is four times the index
`define AUX_CTL_INDEX 8'h11
`define AUX_CTL_ADDR ({22'h000000, `AUX_CTL_INDEX, 2'b00})
`define AUX_STAT_ADDR 32'h0000_0080

// control register fields
`define AUX_SEL_HI 7
`define AUX_SEL_LO 5
`define AUX_SRC_HI 4
`define AUX_SRC_LO 2
`define AUX_VAL_BIT 1
`define AUX_EN_BIT 0
`define AUX_CTL_RESET 8'h00

`endif

// *** aux_pin_pkg.sv ***
// types shared by the auxiliary pin output selector
package aux_pin_pkg;

    // source groups for the pin output
    typedef enum logic [2:0] {
        SRC_RX0 = 3'h0,
        SRC_RX1 = 3'h1,
        SRC_RX2 = 3'h2,
        SRC_RX3 = 3'h3,
        SRC_DEV = 3'h4,
        SRC_RSVD = 3'h5,
        SRC_TX0 = 3'h6,
        SRC_TX1 = 3'h7
    } pin_src_e;

    // signal codes when device status is the source
    typedef enum logic [2:0] {
        DEV_LOCAL = 3'h0,
        DEV_LOCK_OR = 3'h1,
        DEV_LOCK_AND = 3'h2,
        DEV_PASS_AND = 3'h3,
        DEV_FSYNC = 3'h4
    } dev_sel_e;

    // signal codes when a transmit port is the source
    typedef enum logic [2:0] {
        TX_PASS_AND = 3'h0,
        TX_PASS_OR = 3'h1,
        TX_FRAME = 3'h2,
        TX_LINE = 3'h3,
        TX_SYNCED = 3'h4,
        TX_INTR = 3'h5
    } tx_sel_e;

endpackage

// *** pin_observer.sv ***
// pin wire as seen by external logic: pulled low while undriven
`timescale 1ns/1ps

module pin_observer (
    input wire logic pinOut,
    input wire logic pinOe,
    output logic pinLevel
);
    // a floating pin would hide a dead driver, so the board pull-down wins
    assign pinLevel = pinOe ? pinOut : 1'b0;
endmodule // pin_observer

// *** rx_sig_select.sv ***
// per receive port signal selector
`timescale 1ns/1ps

module rx_sig_select (
    input wire logic [2:0] pinSignalSelect,
    input wire logic [3:0] remotePins,
    input wire logic lock,
    input wire logic pass,
    input wire logic frameValid,
    input wire logic lineValid,
    output logic sig
);

    // codes 0..3 pick a forwarded remote pin, upper codes the port status
    wire [7:0] choices = {lineValid, frameValid, pass, lock, remotePins};
    assign sig = choices[pinSignalSelect];

endmodule // rx_sig_select

// *** tb.sv ***
// self-checking bench for the auxiliary pin one selector
`timescale 1ns/1ps
`include "aux_pin_cfg.svh"

module tb;
    logic ref_clk = 0, srst = 1, hsel = 0, hwrite = 0, hready = 1, frameSyncPulse = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0, txFrameActive = 0, txLineActive = 0, txSynced = 0, txInterrupt = 0;
    logic [2:0] hsize = 3'h2;
    logic [15:0] rxRemotePins = 0;
    logic [3:0] rxLock = 0, rxPass = 0, rxFrameValid = 0, rxLineValid = 0, rxPortEnable = 0;
    logic [7:0] txRxSelect = 0;
    logic hreadyout, hresp, auxPinOneOut, auxPinOneOe, pinLevel;
    int bad_count = 0, n_checks = 0;

    aux_pin1_output_mux aux_pin1_output_mux_i (.*);
    pin_observer pin_observer_i (.pinOut(auxPinOneOut), .pinOe(auxPinOneOe), .pinLevel(pinLevel));

    // 40 MHz
    initial forever #12.5 ref_clk = ~ref_clk;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // hold the phase until hreadyout seen high; data sampled while settled
    task rdy(output logic [31:0] d);
        int i;
        i = 0;
        @(negedge ref_clk);
        while (hreadyout !== 1'b1) begin
            i++;
            if (i > 50) begin
                bad_count++;
                $display("[ERR] %0t bus wait timed out", $time);
                wrap_up;
            end
            @(negedge ref_clk);
        end
        d = hrdata;
        @(posedge ref_clk);
    endtask

    task bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        logic [31:0] x;
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        rdy(x);
        htrans <= 2'h0;
        hwdata <= wd;
        rdy(rd);
    endtask

    task wr(input logic [7:0] c);
        logic [31:0] d;
        bus(1'b1, `AUX_CTL_ADDR, {24'h0, c}, d);
    endtask

    // output is one register stage behind its inputs
    task pin(input logic e);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(auxPinOneOut, e);
    endtask

    task t_rx;
        logic [15:0] rp;
        logic [3:0] lk, ps, fv, lv;
        for (int p = 0; p < 4; p++) for (int c = 0; c < 8; c++) begin
            wr({c[2:0], p[2:0], 2'b01});
            for (int v = 0; v < 2; v++) begin
                rp = {16{v == 0}};
                lk = {4{v == 0}};
                ps = lk;
                fv = lk;
                lv = lk;
                case (c)
                    4: lk[p] = v[0];
                    5: ps[p] = v[0];
                    6: fv[p] = v[0];
                    7: lv[p] = v[0];
                    default: rp[4 * p + c] = v[0];
                endcase
                @(posedge ref_clk);
                rxRemotePins <= rp;
                rxLock <= lk;
                rxPass <= ps;
                rxFrameValid <= fv;
                rxLineValid <= lv;
                pin(v[0]);
            end
        end
        $display("receive source test done");
    endtask

    task dst(input logic [2:0] c, input logic [3:0] en, lk, ps, input logic v, fs, e);
        wr({c, 3'h4, v, 1'b1});
        rxPortEnable <= en;
        rxLock <= lk;
        rxPass <= ps;
        frameSyncPulse <= fs;
        pin(e);
    endtask

    task t_dev;
        dst(3'h0, 4'h0, 4'h0, 4'h0, 1'b1, 1'b0, 1'b1);
        dst(3'h0, 4'hF, 4'hF, 4'hF, 1'b0, 1'b1, 1'b0);
        dst(3'h1, 4'h5, 4'h4, 4'h0, 1'b0, 1'b0, 1'b1);
        dst(3'h1, 4'h5, 4'hA, 4'h0, 1'b0, 1'b0, 1'b0);
        dst(3'h2, 4'h5, 4'h5, 4'h0, 1'b0, 1'b0, 1'b1);
        dst(3'h2, 4'h5, 4'hE, 4'h0, 1'b0, 1'b0, 1'b0);
        dst(3'h3, 4'h5, 4'h0, 4'h5, 1'b0, 1'b0, 1'b1);
        dst(3'h3, 4'h5, 4'hF, 4'hE, 1'b0, 1'b0, 1'b0);
        dst(3'h4, 4'h0, 4'h0, 4'h0, 1'b0, 1'b1, 1'b1);
        dst(3'h4, 4'hF, 4'hF, 4'hF, 1'b1, 1'b0, 1'b0);
        dst(3'h5, 4'hF, 4'hF, 4'hF, 1'b1, 1'b1, 1'b0);
        dst(3'h7, 4'hF, 4'hF, 4'hF, 1'b1, 1'b1, 1'b0);
        $display("device status test done");
    endtask

    task tst(input logic t, input logic [2:0] c, input logic [7:0] s, input logic [3:0] ps, input logic e);
        wr({c, 2'b11, t, 2'b01});
        {txInterrupt, txSynced, txLineActive, txFrameActive} <= s;
        rxPass <= ps;
        pin(e);
    endtask

    // port 0 owns receive ports 0-1, port 1 owns 2-3
    task t_tx;
        logic [7:0] s;
        @(posedge ref_clk);
        txRxSelect <= 8'hC3;
        tst(1'b0, 3'h0, 8'h00, 4'h3, 1'b1);
        tst(1'b0, 3'h0, 8'h00, 4'hD, 1'b0);
        tst(1'b0, 3'h1, 8'h00, 4'h2, 1'b1);
        tst(1'b0, 3'h1, 8'h00, 4'hC, 1'b0);
        tst(1'b1, 3'h0, 8'h00, 4'hC, 1'b1);
        tst(1'b1, 3'h1, 8'h00, 4'h3, 1'b0);
        for (int t = 0; t < 2; t++) for (int k = 0; k < 4; k++) begin
            s = 8'h01 << (2 * k + t);
            tst(t[0], 3'(k + 2), s, 4'h0, 1'b1);
            tst(t[0], 3'(k + 2), ~s, 4'h0, 1'b0);
        end
        tst(1'b1, 3'h7, 8'hFF, 4'hF, 1'b0);
        $display("transmit source test done");
    endtask

    task t_oe;
        logic [31:0] d;
        bus(1'b0, `AUX_CTL_ADDR, 32'h0, d);
        chk(d, {24'h0, `AUX_CTL_RESET});
        chk(auxPinOneOe, 1'b0);
        wr(8'h13);
        pin(1'b1);
        chk(pinLevel, 1'b1);
        bus(0, `AUX_STAT_ADDR, 32'h0, d);
        chk(d[1:0], 2'h3);
        wr(8'h12);
        pin(1'b1);
        chk(auxPinOneOe, 1'b0);
        chk(pinLevel, 1'b0);
        bus(1'b1, 32'h0000_0040, 32'hFF, d);
        bus(1'b0, 32'h0000_0040, 32'h0, d);
        chk(d, 32'h0);
        bus(1'b0, `AUX_CTL_ADDR, 32'h0, d);
        chk(d, 32'h12);
        $display("enable and register test done");
    endtask

    // reset in mid-run clears the control and the pin drive
    task t_rst;
        logic [31:0] d;
        wr(8'h13);
        pin(1'b1);
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        @(negedge ref_clk);
        chk(auxPinOneOe, 1'b0);
        chk(auxPinOneOut, 1'b0);
        bus(1'b0, `AUX_CTL_ADDR, 32'h0, d);
        chk(d, {24'h0, `AUX_CTL_RESET});
        $display("mid-run reset test done");
    endtask

    initial begin
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        t_oe();
        t_rst();
        t_rx();
        t_dev();
        t_tx();
        wrap_up();
    end
endmodule // tb
